/* rtl/meas_defines.svh */
// Purpose: constants for the charge-time measurement control block
// Assumes: one 16-bit control register on a plain register port
// Notes:   offsets, field positions, reset value
`ifndef MEAS_DEFINES_SVH
`define MEAS_DEFINES_SVH

`define MEAS_ADDR_W          4
`define MEAS_CTRL_OFFSET     4'h0
`define MEAS_CTRL_RESET      16'h0000
`define MEAS_CTRL_WMASK      16'hbfff
`define MEAS_BIT_ON          15
`define MEAS_BIT_UNUSED      14
`define MEAS_BIT_IDLE_STOP   13
`define MEAS_BIT_DELAY_GEN   12
`define MEAS_BIT_ACCEPT      11
`define MEAS_BIT_ORDER       10
`define MEAS_BIT_DISCHARGE   9
`define MEAS_BIT_TRIG        8
`define MEAS_BIT_B_POL       7
`define MEAS_BIT_B_SRC_HI    6
`define MEAS_BIT_B_SRC_LO    5
`define MEAS_BIT_A_POL       4
`define MEAS_BIT_A_SRC_HI    3
`define MEAS_BIT_A_SRC_LO    2
`define MEAS_BIT_B_SEEN      1
`define MEAS_BIT_A_SEEN      0

`endif

/* rtl/meas_pkg.sv */
// Purpose: types for the charge-time measurement control block
// Assumes: constants come from meas_defines.svh
// Notes:   whole module state is one packed struct
`include "meas_defines.svh"
package meas_pkg;

  typedef enum logic [1:0] {
    SRC_TIMER_ONE = 2'b00,
    SRC_OC_ONE    = 2'b01,
    SRC_PIN_B     = 2'b10,
    SRC_PIN_A     = 2'b11
  } edge_src_t;

  typedef struct packed {
    logic                      wr;
    logic                      rd;
    logic [`MEAS_ADDR_W-1:0]   addr;
    logic [15:0]               wdata;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [2:0]  sync_a;
    logic [2:0]  sync_b;
    logic        lvl_a;
    logic        lvl_b;
    logic        prev_oc;
    logic        prev_tm;
    logic [15:0] rdata;
    logic        src_on;
    logic        delay_out;
    logic        trig;
    logic        discharge;
    logic        active;
  } meas_state_t;

endpackage : meas_pkg

/* rtl/edge_timed_current_source_ctrl.sv */
// Purpose: control of an edge-timed charge measurement current source
// Assumes: 20 MHz clk_i, synchronous active-low reset, plain register port
// Notes:   edge pins pass three flops; compare and timer inputs are on clk_i
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "meas_defines.svh"

module edge_timed_current_source_ctrl (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire meas_pkg::reg_req_t req_i,
  output logic [15:0]            rdata_o,
  input  wire logic              ext_edge_pin_a_i,
  input  wire logic              ext_edge_pin_b_i,
  input  wire logic              output_compare_one_i,
  input  wire logic              timer_one_i,
  input  wire logic              idle_i,
  output logic                   current_source_on_o,
  output logic                   source_discharge_o,
  output logic                   delay_out_o,
  output logic                   trigger_out_o,
  output logic                   unit_active_o
);
  import meas_pkg::*;

  meas_state_t q;
  meas_state_t next_q;

  function automatic logic src_level(input logic [1:0] sel, input logic pa, input logic pb,
                                     input logic oc, input logic tm);
    unique case (edge_src_t'(sel))
      SRC_PIN_A:     src_level = pa;
      SRC_PIN_B:     src_level = pb;
      SRC_OC_ONE:    src_level = oc;
      SRC_TIMER_ONE: src_level = tm;
    endcase
  endfunction : src_level

  function automatic logic edge_hit(input logic pol, input logic old_l, input logic new_l);
    edge_hit = pol ? (!old_l && new_l) : (old_l && !new_l);
  endfunction : edge_hit

  logic        ctrl_sel;
  logic        run;
  logic        new_lvl_a;
  logic        new_lvl_b;
  logic        old_src_a;
  logic        cur_src_a;
  logic        old_src_b;
  logic        cur_src_b;
  logic        hit_a;
  logic        hit_b;
  logic [15:0] ctrl_w;

  always_comb begin
    next_q = q;
    ctrl_sel = (req_i.addr == `MEAS_CTRL_OFFSET);
    // idle stop only freezes the unit while the device idles
    run = q.ctrl[`MEAS_BIT_ON] && !(idle_i && q.ctrl[`MEAS_BIT_IDLE_STOP]);
    // pins: a change counts once the second and third flops agree
    next_q.sync_a = {q.sync_a[1:0], ext_edge_pin_a_i};
    next_q.sync_b = {q.sync_b[1:0], ext_edge_pin_b_i};
    new_lvl_a = (q.sync_a[1] == q.sync_a[2]) ? q.sync_a[2] : q.lvl_a;
    new_lvl_b = (q.sync_b[1] == q.sync_b[2]) ? q.sync_b[2] : q.lvl_b;
    next_q.lvl_a = new_lvl_a;
    next_q.lvl_b = new_lvl_b;
    next_q.prev_oc = output_compare_one_i;
    next_q.prev_tm = timer_one_i;
    old_src_a = src_level(q.ctrl[`MEAS_BIT_A_SRC_HI:`MEAS_BIT_A_SRC_LO],
                          q.lvl_a, q.lvl_b, q.prev_oc, q.prev_tm);
    cur_src_a = src_level(q.ctrl[`MEAS_BIT_A_SRC_HI:`MEAS_BIT_A_SRC_LO],
                          new_lvl_a, new_lvl_b, output_compare_one_i, timer_one_i);
    old_src_b = src_level(q.ctrl[`MEAS_BIT_B_SRC_HI:`MEAS_BIT_B_SRC_LO],
                          q.lvl_a, q.lvl_b, q.prev_oc, q.prev_tm);
    cur_src_b = src_level(q.ctrl[`MEAS_BIT_B_SRC_HI:`MEAS_BIT_B_SRC_LO],
                          new_lvl_a, new_lvl_b, output_compare_one_i, timer_one_i);
    hit_a = run && q.ctrl[`MEAS_BIT_ACCEPT]
            && edge_hit(q.ctrl[`MEAS_BIT_A_POL], old_src_a, cur_src_a);
    hit_b = run && q.ctrl[`MEAS_BIT_ACCEPT]
            && edge_hit(q.ctrl[`MEAS_BIT_B_POL], old_src_b, cur_src_b)
            && (!q.ctrl[`MEAS_BIT_ORDER] || q.ctrl[`MEAS_BIT_A_SEEN] || hit_a);
    // register write; bit 14 is not stored
    ctrl_w = q.ctrl;
    if (req_i.wr && ctrl_sel) begin
      ctrl_w = req_i.wdata & `MEAS_CTRL_WMASK;
    end
    // hardware set wins over a software clear in the same cycle
    ctrl_w[`MEAS_BIT_A_SEEN] = ctrl_w[`MEAS_BIT_A_SEEN] | hit_a;
    ctrl_w[`MEAS_BIT_B_SEEN] = ctrl_w[`MEAS_BIT_B_SEEN] | hit_b;
    next_q.ctrl = ctrl_w;
    // read data valid the cycle after the strobe; unmapped reads zero
    next_q.rdata = (req_i.rd && ctrl_sel) ? (q.ctrl & `MEAS_CTRL_WMASK) : 16'h0000;
    next_q.active = run;
    next_q.discharge = q.ctrl[`MEAS_BIT_DISCHARGE];
    // source charges between edge A and edge B, never while grounded
    next_q.src_on = run && q.ctrl[`MEAS_BIT_A_SEEN] && !q.ctrl[`MEAS_BIT_B_SEEN]
                    && !q.ctrl[`MEAS_BIT_DISCHARGE];
    next_q.delay_out = run && q.ctrl[`MEAS_BIT_DELAY_GEN]
                       && q.ctrl[`MEAS_BIT_A_SEEN] && !q.ctrl[`MEAS_BIT_B_SEEN];
    next_q.trig = run && q.ctrl[`MEAS_BIT_TRIG] && hit_b;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q <= '0;
      q.ctrl <= `MEAS_CTRL_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign rdata_o             = q.rdata;
  assign current_source_on_o = q.src_on;
  assign source_discharge_o  = q.discharge;
  assign delay_out_o         = q.delay_out;
  assign trigger_out_o       = q.trig;
  assign unit_active_o       = q.active;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  logic wr_ctrl;
  assign wr_ctrl = req_i.wr && ctrl_sel;

  chk_off_no_edges: assert property (
    (!q.ctrl[`MEAS_BIT_ON] && !wr_ctrl) |=> $stable(q.ctrl[1:0]))
    else $error("edge seen bit moved while unit off");

  chk_delay_gen_gate: assert property (
    delay_out_o |-> $past(q.ctrl[`MEAS_BIT_DELAY_GEN]) && $past(q.ctrl[`MEAS_BIT_ON]))
    else $error("delay output without delay generation enabled");

  chk_accept_blocks: assert property (
    (!q.ctrl[`MEAS_BIT_ACCEPT] && !wr_ctrl) |=> $stable(q.ctrl[1:0]))
    else $error("edge taken while edges blocked");

  chk_order_forced: assert property (
    (q.ctrl[`MEAS_BIT_ORDER] && !q.ctrl[`MEAS_BIT_A_SEEN] && !hit_a
     && !q.ctrl[`MEAS_BIT_B_SEEN] && !wr_ctrl) |=> !q.ctrl[`MEAS_BIT_B_SEEN])
    else $error("edge B taken before edge A");

  chk_discharge_path: assert property (
    q.ctrl[`MEAS_BIT_DISCHARGE] |=> source_discharge_o && !current_source_on_o)
    else $error("discharge not applied or source still on");

  chk_a_polarity: assert property (
    (run && q.ctrl[`MEAS_BIT_ACCEPT] && q.ctrl[`MEAS_BIT_A_POL] && !old_src_a && cur_src_a)
    |=> q.ctrl[`MEAS_BIT_A_SEEN])
    else $error("rising edge A not recorded");

  chk_b_pin_a_source: assert property (
    (run && q.ctrl[`MEAS_BIT_ACCEPT] && !q.ctrl[`MEAS_BIT_ORDER]
     && q.ctrl[`MEAS_BIT_B_SRC_HI:`MEAS_BIT_B_SRC_LO] == 2'b11
     && q.ctrl[`MEAS_BIT_B_POL] && !q.lvl_a && new_lvl_a) |=> q.ctrl[`MEAS_BIT_B_SEEN])
    else $error("edge B from pin A not recorded");

  chk_bit14_zero: assert property (
    (req_i.rd && ctrl_sel) |=> rdata_o[14] == 1'b0)
    else $error("unimplemented bit read nonzero");

  chk_seen_sticky: assert property (
    (q.ctrl[`MEAS_BIT_A_SEEN] && !wr_ctrl) |=> q.ctrl[`MEAS_BIT_A_SEEN])
    else $error("edge A seen bit lost without write");

  chk_b_polarity: assert property (
    (run && q.ctrl[`MEAS_BIT_ACCEPT] && !q.ctrl[`MEAS_BIT_ORDER]
     && !q.ctrl[`MEAS_BIT_B_POL] && old_src_b && !cur_src_b) |=> q.ctrl[`MEAS_BIT_B_SEEN])
    else $error("falling edge B not recorded");

  chk_active_on: assert property (
    run |=> unit_active_o)
    else $error("unit not active while enabled");

  chk_active_off: assert property (
    !run |=> !unit_active_o)
    else $error("unit active while disabled");

  chk_idle_stop: assert property (
    (idle_i && q.ctrl[`MEAS_BIT_IDLE_STOP]) |=> !unit_active_o)
    else $error("unit kept running in idle with idle stop set");

  chk_off_outputs: assert property (
    !run |=> !current_source_on_o && !delay_out_o && !trigger_out_o)
    else $error("unit output driven while unit disabled");

  chk_off_no_hits: assert property (
    !run |-> !hit_a && !hit_b)
    else $error("edge detected while unit disabled");

  chk_source_needs_run: assert property (
    current_source_on_o |-> $past(run))
    else $error("current source on while unit disabled");

  chk_delay_needs_run: assert property (
    delay_out_o |-> $past(run))
    else $error("delay output while unit disabled");

  chk_delay_gen_off: assert property (
    !q.ctrl[`MEAS_BIT_DELAY_GEN] |=> !delay_out_o)
    else $error("delay output with delay generation off");

  chk_delay_gen_on: assert property (
    (run && q.ctrl[`MEAS_BIT_DELAY_GEN] && q.ctrl[`MEAS_BIT_A_SEEN]
     && !q.ctrl[`MEAS_BIT_B_SEEN]) |=> delay_out_o)
    else $error("delay output missing between edges");

  chk_blocked_no_hit: assert property (
    !q.ctrl[`MEAS_BIT_ACCEPT] |-> !hit_a && !hit_b)
    else $error("edge detected while edges blocked");

  chk_accept_lets_a: assert property (
    (run && q.ctrl[`MEAS_BIT_ACCEPT] && q.ctrl[`MEAS_BIT_A_POL] == cur_src_a
     && old_src_a != cur_src_a) |-> hit_a)
    else $error("accepted edge A not detected");

  chk_order_holds_b: assert property (
    (q.ctrl[`MEAS_BIT_ORDER] && !q.ctrl[`MEAS_BIT_A_SEEN] && !hit_a) |-> !hit_b)
    else $error("edge B detected ahead of edge A");

  chk_order_free: assert property (
    (run && q.ctrl[`MEAS_BIT_ACCEPT] && !q.ctrl[`MEAS_BIT_ORDER]
     && q.ctrl[`MEAS_BIT_B_POL] == cur_src_b && old_src_b != cur_src_b) |-> hit_b)
    else $error("edge B held back with ordering off");

  chk_discharge_off: assert property (
    !q.ctrl[`MEAS_BIT_DISCHARGE] |=> !source_discharge_o)
    else $error("source grounded with discharge off");

  chk_source_ungrounded: assert property (
    current_source_on_o |-> !source_discharge_o)
    else $error("current source on while grounded");

  chk_a_falling: assert property (
    (run && q.ctrl[`MEAS_BIT_ACCEPT] && !q.ctrl[`MEAS_BIT_A_POL]
     && old_src_a && !cur_src_a) |=> q.ctrl[`MEAS_BIT_A_SEEN])
    else $error("falling edge A not recorded");

  chk_a_rise_ignored: assert property (
    (!q.ctrl[`MEAS_BIT_A_POL] && !old_src_a && cur_src_a) |-> !hit_a)
    else $error("rising edge A taken with falling polarity");

  chk_b_pin_b_source: assert property (
    (run && q.ctrl[`MEAS_BIT_ACCEPT] && !q.ctrl[`MEAS_BIT_ORDER]
     && q.ctrl[`MEAS_BIT_B_SRC_HI:`MEAS_BIT_B_SRC_LO] == 2'b10
     && q.ctrl[`MEAS_BIT_B_POL] && !q.lvl_b && new_lvl_b) |=> q.ctrl[`MEAS_BIT_B_SEEN])
    else $error("edge B from pin B not recorded");

  chk_b_oc_source: assert property (
    (run && q.ctrl[`MEAS_BIT_ACCEPT] && !q.ctrl[`MEAS_BIT_ORDER]
     && q.ctrl[`MEAS_BIT_B_SRC_HI:`MEAS_BIT_B_SRC_LO] == 2'b01
     && q.ctrl[`MEAS_BIT_B_POL] && !q.prev_oc && output_compare_one_i)
    |=> q.ctrl[`MEAS_BIT_B_SEEN])
    else $error("edge B from compare not recorded");

  chk_b_timer_source: assert property (
    (run && q.ctrl[`MEAS_BIT_ACCEPT] && !q.ctrl[`MEAS_BIT_ORDER]
     && q.ctrl[`MEAS_BIT_B_SRC_HI:`MEAS_BIT_B_SRC_LO] == 2'b00
     && q.ctrl[`MEAS_BIT_B_POL] && !q.prev_tm && timer_one_i)
    |=> q.ctrl[`MEAS_BIT_B_SEEN])
    else $error("edge B from timer not recorded");

  chk_bit14_store: assert property (
    q.ctrl[`MEAS_BIT_UNUSED] == 1'b0)
    else $error("unimplemented bit stored");

  chk_unmapped_read: assert property (
    (req_i.rd && !ctrl_sel) |=> rdata_o == 16'h0000)
    else $error("unmapped read returned nonzero");

  chk_seen_b_sticky: assert property (
    (q.ctrl[`MEAS_BIT_B_SEEN] && !wr_ctrl) |=> q.ctrl[`MEAS_BIT_B_SEEN])
    else $error("edge B seen bit lost without write");

  chk_hit_a_sets: assert property (
    hit_a |=> q.ctrl[`MEAS_BIT_A_SEEN])
    else $error("detected edge A not recorded");

  chk_hit_b_sets: assert property (
    hit_b |=> q.ctrl[`MEAS_BIT_B_SEEN])
    else $error("detected edge B not recorded");

  chk_b_rising: assert property (
    (run && q.ctrl[`MEAS_BIT_ACCEPT] && !q.ctrl[`MEAS_BIT_ORDER]
     && q.ctrl[`MEAS_BIT_B_POL] && !old_src_b && cur_src_b) |=> q.ctrl[`MEAS_BIT_B_SEEN])
    else $error("rising edge B not recorded");

  chk_b_rise_ignored: assert property (
    (!q.ctrl[`MEAS_BIT_B_POL] && !old_src_b && cur_src_b) |-> !hit_b)
    else $error("rising edge B taken with falling polarity");

  cov_edge_pair: cover property (hit_a ##[1:50] hit_b);
  cov_delay_out: cover property ($rose(delay_out_o));
  cov_trigger:   cover property (trigger_out_o);
  cov_order_block: cover property (q.ctrl[`MEAS_BIT_ORDER] && !q.ctrl[`MEAS_BIT_A_SEEN]
                                   && q.ctrl[`MEAS_BIT_B_POL] && !old_src_b && cur_src_b);
  cov_idle_stop: cover property (q.ctrl[`MEAS_BIT_ON] && q.ctrl[`MEAS_BIT_IDLE_STOP] && idle_i);

endmodule : edge_timed_current_source_ctrl

/* tb/edge_src_model.sv */
// Purpose: edge source model for the measurement control block
// Assumes: toggle requests come by non-blocking assignment after a clock edge
// Notes:   lines hold their level between edges, as real sources do
`timescale 1ns/1ps
module edge_src_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] tgl_i,
  output logic            pin_a_o,
  output logic            pin_b_o,
  output logic            oc_o,
  output logic            tm_o
);
  initial {tm_o, oc_o, pin_b_o, pin_a_o} = 4'h0;
  // compare and timer move on clk_i only, so the block owes them no sync
  always @(posedge clk_i) begin
    {tm_o, oc_o, pin_b_o, pin_a_o} <= {tm_o, oc_o, pin_b_o, pin_a_o} ^ tgl_i;
  end
endmodule : edge_src_model

/* tb/tb.sv */
// Purpose: self-checking bench for the measurement control block
// Assumes: one clock, register port strobes one cycle long
// Notes:   line levels tracked here so edge polarity can be predicted
`timescale 1ns/1ps
`include "meas_defines.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module tb;
  import meas_pkg::*;
  logic        clk_i = 0, reset_n_i = 0, idle_i = 0;
  reg_req_t    req = '0;
  logic [3:0]  tgl = 4'h0, lv = 4'h0;
  logic [15:0] rdata, got, c;
  logic        pa, pb, oc, tm, src_on, dis, dly, trig, act, trig_seen = 0;
  int          mismatches = 0, n_compared = 0;
  always #25 clk_i = ~clk_i;
  // trigger is a one-cycle pulse, so catch it here
  always @(posedge clk_i) if (trig === 1'b1) trig_seen <= 1'b1;
  edge_src_model part_u (.clk_i(clk_i), .tgl_i(tgl), .pin_a_o(pa), .pin_b_o(pb),
    .oc_o(oc), .tm_o(tm));
  edge_timed_current_source_ctrl dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req),
    .rdata_o(rdata), .ext_edge_pin_a_i(pa), .ext_edge_pin_b_i(pb),
    .output_compare_one_i(oc), .timer_one_i(tm), .idle_i(idle_i),
    .current_source_on_o(src_on), .source_discharge_o(dis), .delay_out_o(dly),
    .trigger_out_o(trig), .unit_active_o(act));
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i) req <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_i) req <= '0;
    #1 got = rdata;
  endtask : rd
  // one edge on line i, then room for the pin sync stages
  task automatic kick(input int i);
    lv[i] = ~lv[i];
    @(posedge clk_i) tgl <= 4'h1 << i;
    @(posedge clk_i) tgl <= 4'h0;
    repeat (8) @(posedge clk_i);
  endtask : kick
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #(50 * 20000);
    mismatches++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(`MEAS_CTRL_OFFSET); `CHK("ctrl reset", 16'h0000, got)
    wr(`MEAS_CTRL_OFFSET, 16'h7fff);
    rd(`MEAS_CTRL_OFFSET); `CHK("bit14 masked", 16'h3fff, got)
    `CHK("discharge on", 1'b1, dis)
    `CHK("unit off", 1'b0, act)
    wr(4'h5, 16'hffff);
    rd(4'h5); `CHK("unmapped read", 16'h0000, got)
    wr(`MEAS_CTRL_OFFSET, 16'ha000);
    rd(`MEAS_CTRL_OFFSET); `CHK("discharge off", 1'b0, dis)
    `CHK("unit on", 1'b1, act)
    @(posedge clk_i) idle_i <= 1'b1;
    rd(`MEAS_CTRL_OFFSET); `CHK("idle stop", 1'b0, act)
    @(posedge clk_i) idle_i <= 1'b0;
    // pins assumed routed by software before delay generation starts
    wr(`MEAS_CTRL_OFFSET, 16'h9dbc);
    kick(2);
    rd(`MEAS_CTRL_OFFSET); `CHK("b before a", 16'h9dbc, got)
    kick(0);
    rd(`MEAS_CTRL_OFFSET); `CHK("a seen", 16'h9dbd, got)
    `CHK("source on", 1'b1, src_on)
    `CHK("delay out", 1'b1, dly)
    kick(2);
    kick(2);
    rd(`MEAS_CTRL_OFFSET); `CHK("b seen", 16'h9dbf, got)
    `CHK("trigger", 1'b1, trig_seen)
    `CHK("source off", 1'b0, src_on)
    wr(`MEAS_CTRL_OFFSET, 16'h9dbc);
    rd(`MEAS_CTRL_OFFSET); `CHK("seen cleared", 16'h9dbc, got)
    wr(`MEAS_CTRL_OFFSET, 16'h880c);
    kick(0);
    rd(`MEAS_CTRL_OFFSET); `CHK("a falling", 16'h880d, got)
    wr(`MEAS_CTRL_OFFSET, 16'h880c);
    kick(0);
    rd(`MEAS_CTRL_OFFSET); `CHK("a rise ignored", 16'h880c, got)
    wr(`MEAS_CTRL_OFFSET, 16'h800c);
    kick(0);
    rd(`MEAS_CTRL_OFFSET); `CHK("edges blocked", 16'h800c, got)
    // both polarities per source, so falling edge B is exercised too
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 4; j++) begin
        c = 16'h8800 | (16'(k) << 5);
        c[`MEAS_BIT_B_POL] = j[1];
        wr(`MEAS_CTRL_OFFSET, c);
        kick(3 - k);
        rd(`MEAS_CTRL_OFFSET); `CHK("b source", lv[3 - k] == j[1], got[1])
      end
    end
    // mid-run reset must bring back the cleared register
    @(posedge clk_i) reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(`MEAS_CTRL_OFFSET); `CHK("ctrl after reset", 16'h0000, got)
    `CHK("active after reset", 1'b0, act)
    final_report();
  end
endmodule : tb
